// ---- ukl_pkg.sv ----
// package: register map, field positions, reset values and timing of the link control block
package ukl_pkg;

  // =====================================================================
  // register offsets
  localparam logic [7:0] UKL_OFF_USB_STATUS_CTRL = 8'h3C;
  localparam logic [7:0] UKL_OFF_SYSTEM_CTRL     = 8'h3D;
  localparam logic [7:0] UKL_OFF_IFACE_SELECT    = 8'h3E;
  localparam logic [7:0] UKL_OFF_PIPE_DIRECTION  = 8'h41;
  localparam logic [7:0] UKL_OFF_DEV_ADDR_WAKE   = 8'h42;
  localparam logic [7:0] UKL_OFF_EP_STALL        = 8'h43;
  localparam logic [7:0] UKL_OFF_EP_ACCESSED     = 8'h44;
  localparam logic [7:0] UKL_OFF_ENGINE_STATUS   = 8'h45;
  localparam logic [7:0] UKL_OFF_EP_ENABLE       = 8'h47;
  localparam logic [7:0] UKL_OFF_CUR_ADDR        = 8'h4B;

  // =====================================================================
  // field positions
  localparam int UKL_USC_SUSPEND   = 0;
  localparam int UKL_USC_REMOTE_WAKE_PULSE_BIT      = 1;
  localparam int UKL_USC_RESUME    = 3;
  localparam int UKL_USC_KD_IN     = 4;
  localparam int UKL_USC_KC_IN     = 5;
  localparam int UKL_USC_KD_OUT    = 6;
  localparam int UKL_USC_KC_OUT    = 7;
  localparam int UKL_SCC_CLK_EN    = 3;
  localparam int UKL_SCC_DEEP_SUSP = 4;
  localparam int UKL_SEL_PS2       = 4;
  localparam int UKL_SEL_USB       = 5;
  localparam int UKL_ENGINE_STATUS_ADR_SET  = 0;
  localparam int UKL_ENGINE_STATUS_FIFO0_ERROR_FLAG   = 1;
  localparam int UKL_ENGINE_STATUS_OUT      = 2;
  localparam int UKL_ENGINE_STATUS_IN       = 3;
  localparam int UKL_ENGINE_STATUS_NAK      = 4;
  localparam int UKL_ENGINE_STATUS_CRC_ERR  = 5;
  localparam int UKL_ENGINE_STATUS_EOT      = 6;
  localparam int UKL_ENGINE_STATUS_NMI      = 7;

  // =====================================================================
  // reset values and widths
  localparam int         UKL_NUM_EP        = 3;
  localparam logic [2:0] UKL_EP_RESET_ONES = 3'h7;
  localparam logic [2:0] UKL_EP_RESET_ZERO = 3'h0;
  localparam logic [7:0] UKL_BYTE_ZERO     = 8'h00;
  localparam logic [7:0] UKL_USC_RESET     = 8'hC0;
  localparam logic [7:0] UKL_SCC_RESET     = 8'h08;

  // =====================================================================
  // timing
  localparam int UKL_CLK_HZ          = 25_000_000;
  localparam int UKL_IDLE_US         = 3000;
  localparam int UKL_IDLE_CYCLES     = (UKL_CLK_HZ / 1_000_000) * UKL_IDLE_US;
  localparam int UKL_TOGGLE_LOW_CYC  = 10;
  localparam int UKL_WAKE_PULSE_US   = 10_000;
  localparam int UKL_WAKE_CYCLES     =
    (UKL_CLK_HZ / 1_000_000) * UKL_WAKE_PULSE_US;
  localparam int UKL_CNT_W           = 20;

  // =====================================================================
  // bundled engine events and block state
  typedef struct packed {
    logic       setup_done;
    logic [6:0] setup_addr;
    logic       in_read_done;
    logic       in_token;
    logic       nak_sent;
    logic       out_received;
    logic       crc_error;
    logic       fifo0_error;
    logic       end_of_trans;
    logic [2:0] ep_access;
  } ukl_sie_ev_t;

  typedef struct packed {
    logic [7:0] usb_status_control_reg;
    logic [7:0] system_control_reg;
    logic [7:0] sel;
    logic [2:0] pipe_dir;
    logic [7:0] addr_wake;
    logic [2:0] stall;
    logic [2:0] accessed;
    logic [7:0] engine_status;
    logic [2:0] ep_en;
    logic [6:0] cur_addr;
    logic [6:0] req_addr;
    logic       req_addr_v;
    logic [UKL_CNT_W-1:0] idle_cnt;
    logic [UKL_CNT_W-1:0] wake_cnt;
    logic [3:0] tog_cnt;
    logic       toggle_clr;
    logic       usb_irq;
    logic       dev_reset;
    logic [7:0] rdata;
  } ukl_state_t;

endpackage : ukl_pkg

// ---- ukl_link_ctrl.sv ----
// module: suspend, resume, wake-up, interface select and endpoint registers
// Contract
// RL1: idle over 3 ms sets suspend, interrupt
// RL2: clearing clock enable stops usb clock
// RL3: deep suspend with low-voltage reset resets device
// RL4: host resume sets resume bit, interrupt
// RL5: resume end clears suspend, interrupt again
// RL6: remote wake bit sends wake pulse
// RL7: ps2 mode maps minus=data, plus=clock
// RL8: ps2 pin bits 4..7 in status register
// RL9: pin input reads zero unless output one
// RL10: usb mode engine drives both lines
// RL11: both select bits reset to zero
// RL12: address register wake bit0, address 7..1
// RL13: request address loads after setup completes
// RL14: access bits set when host accesses endpoint
// RL15: stall bits per endpoint, reset 111
// RL16: direction bit 1 is IN, default IN
// RL17: low pulse 10 cycles resets toggles
// RL18: enable bit enables endpoints above zero
// RL19: engine status field layout
// RL20: auto address update after next IN read
// RL21: reserved bits read zero, ignore writes; select and system control keep all eight written bits
module ukl_link_ctrl (
  input  wire logic              CLK_SYS_IN,
  input  wire logic              RST_IN,
  input  wire logic [7:0]        ADDR_IN,
  input  wire logic [7:0]        WDATA_IN,
  input  wire logic              WR_IN,
  input  wire logic              RD_IN,
  output logic      [7:0]        RDATA_OUT,
  input  wire logic              LINE_IDLE_IN,
  input  wire logic              HOST_RESUME_IN,
  input  wire logic              LVR_OPTION_IN,
  input  wire ukl_pkg::ukl_sie_ev_t SIE_EV_IN,
  input  wire logic              MINUS_IN,
  input  wire logic              PLUS_IN,
  input  wire logic              SIE_MINUS_IN,
  input  wire logic              SIE_PLUS_IN,
  input  wire logic              SIE_OE_IN,
  output logic                   MINUS_OUT,
  output logic                   MINUS_OE_OUT,
  output logic                   PLUS_OUT,
  output logic                   PLUS_OE_OUT,
  output logic                   USB_CLK_EN_OUT,
  output logic                   DEEP_SUSPEND_OUT,
  output logic                   DEVICE_RESET_OUT,
  output logic                   USB_IRQ_OUT,
  output logic                   WAKE_PULSE_OUT,
  output logic                   TOGGLE_CLEAR_OUT,
  output logic [6:0]             DEVICE_ADDR_OUT,
  output logic [2:0]             PIPE_DIR_OUT,
  output logic [2:0]             EP_STALL_OUT,
  output logic [2:0]             EP_ENABLE_OUT,
  output logic                   USB_MODE_OUT,
  output logic                   PS2_MODE_OUT
);
  import ukl_pkg::*;

  ukl_state_t s_r;
  ukl_state_t s_nxt;
  logic       ps2_mode;
  logic       usb_mode;

  // =====================================================================
  // helpers
  function automatic logic is_wr(input logic [7:0] off);
    is_wr = WR_IN && (ADDR_IN == off);
  endfunction : is_wr

  function automatic logic pin_in(input logic drv, input logic pin);
    pin_in = drv & pin;
  endfunction : pin_in

  assign ps2_mode = s_r.sel[UKL_SEL_PS2] & ~s_r.sel[UKL_SEL_USB]; // [RL7]
  assign usb_mode = ~s_r.sel[UKL_SEL_PS2] & s_r.sel[UKL_SEL_USB]; // [RL10]

  // =====================================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.usb_irq = 1'b0;
    s_nxt.rdata = UKL_BYTE_ZERO;
    s_nxt.usb_status_control_reg[UKL_USC_KD_IN] =
      pin_in(s_r.usb_status_control_reg[UKL_USC_KD_OUT], MINUS_IN) & ps2_mode; // [RL8] [RL9]
    s_nxt.usb_status_control_reg[UKL_USC_KC_IN] =
      pin_in(s_r.usb_status_control_reg[UKL_USC_KC_OUT], PLUS_IN) & ps2_mode; // [RL8] [RL9]

    // idle detection
    if (!LINE_IDLE_IN) begin
      s_nxt.idle_cnt = '0;
    end else if (s_r.idle_cnt < UKL_CNT_W'(UKL_IDLE_CYCLES)) begin
      s_nxt.idle_cnt = s_r.idle_cnt + 1'b1;
    end else if (!s_r.usb_status_control_reg[UKL_USC_SUSPEND]) begin
      s_nxt.usb_status_control_reg[UKL_USC_SUSPEND] = 1'b1; // [RL1]
      s_nxt.usb_irq = 1'b1; // [RL1]
    end

    // resume
    if (HOST_RESUME_IN && !s_r.usb_status_control_reg[UKL_USC_RESUME]) begin
      s_nxt.usb_status_control_reg[UKL_USC_RESUME] = 1'b1; // [RL4]
      s_nxt.usb_irq = 1'b1; // [RL4]
    end else if (!HOST_RESUME_IN && s_r.usb_status_control_reg[UKL_USC_RESUME]) begin
      s_nxt.usb_status_control_reg[UKL_USC_RESUME] = 1'b0;
      s_nxt.usb_status_control_reg[UKL_USC_SUSPEND] = 1'b0; // [RL5]
      s_nxt.idle_cnt = '0;
      s_nxt.usb_irq = 1'b1; // [RL5]
    end

    // remote wake pulse
    if (s_r.wake_cnt != '0) begin
      s_nxt.wake_cnt = s_r.wake_cnt - 1'b1;
    end

    // toggle clear on low pulse of direction bit 0
    if (!s_r.pipe_dir[0]) begin
      if (s_r.tog_cnt < 4'(UKL_TOGGLE_LOW_CYC)) begin
        s_nxt.tog_cnt = s_r.tog_cnt + 1'b1;
      end
    end else begin
      s_nxt.tog_cnt = '0;
    end
    s_nxt.toggle_clr = s_r.pipe_dir[0] &&
      (s_r.tog_cnt >= 4'(UKL_TOGGLE_LOW_CYC)); // [RL17]

    // engine events
    s_nxt.accessed = s_r.accessed | SIE_EV_IN.ep_access; // [RL14]
    s_nxt.engine_status[UKL_ENGINE_STATUS_IN]  = SIE_EV_IN.in_token; // [RL19]
    s_nxt.engine_status[UKL_ENGINE_STATUS_NAK] = SIE_EV_IN.nak_sent; // [RL19]
    s_nxt.engine_status[UKL_ENGINE_STATUS_EOT] = SIE_EV_IN.end_of_trans; // [RL19]
    if (SIE_EV_IN.setup_done) begin
      s_nxt.req_addr = SIE_EV_IN.setup_addr; // [RL13]
      s_nxt.req_addr_v = 1'b1; // [RL13]
      s_nxt.engine_status[UKL_ENGINE_STATUS_OUT] = 1'b0;
    end
    if (s_r.req_addr_v && SIE_EV_IN.in_read_done) begin
      s_nxt.cur_addr = s_r.req_addr; // [RL13]
      s_nxt.req_addr_v = 1'b0;
    end
    if (s_r.engine_status[UKL_ENGINE_STATUS_ADR_SET] && SIE_EV_IN.in_read_done) begin
      s_nxt.cur_addr = s_r.addr_wake[7:1]; // [RL20]
      s_nxt.engine_status[UKL_ENGINE_STATUS_ADR_SET] = 1'b0; // [RL20]
    end

    // register writes
    if (is_wr(UKL_OFF_USB_STATUS_CTRL)) begin
      s_nxt.usb_status_control_reg[UKL_USC_KD_OUT] = WDATA_IN[UKL_USC_KD_OUT]; // [RL8]
      s_nxt.usb_status_control_reg[UKL_USC_KC_OUT] = WDATA_IN[UKL_USC_KC_OUT]; // [RL8]
      if (WDATA_IN[UKL_USC_REMOTE_WAKE_PULSE_BIT]) begin
        s_nxt.wake_cnt = UKL_CNT_W'(UKL_WAKE_CYCLES); // [RL6]
      end
    end else if (is_wr(UKL_OFF_SYSTEM_CTRL)) begin
      s_nxt.system_control_reg = WDATA_IN; // [RL2] [RL3]
    end else if (is_wr(UKL_OFF_IFACE_SELECT)) begin
      s_nxt.sel = WDATA_IN;
    end else if (is_wr(UKL_OFF_PIPE_DIRECTION)) begin
      s_nxt.pipe_dir = WDATA_IN[2:0]; // [RL16] [RL21]
    end else if (is_wr(UKL_OFF_DEV_ADDR_WAKE)) begin
      s_nxt.addr_wake = WDATA_IN; // [RL12]
      if (!s_r.engine_status[UKL_ENGINE_STATUS_ADR_SET]) begin
        s_nxt.cur_addr = WDATA_IN[7:1]; // [RL20]
      end
    end else if (is_wr(UKL_OFF_EP_STALL)) begin
      s_nxt.stall = WDATA_IN[2:0]; // [RL15] [RL21]
    end else if (is_wr(UKL_OFF_ENGINE_STATUS)) begin
      s_nxt.engine_status[UKL_ENGINE_STATUS_NMI]     = WDATA_IN[UKL_ENGINE_STATUS_NMI];
      s_nxt.engine_status[UKL_ENGINE_STATUS_ADR_SET] = WDATA_IN[UKL_ENGINE_STATUS_ADR_SET];
      // flags set by hardware: set wins over a software clear
      s_nxt.engine_status[UKL_ENGINE_STATUS_CRC_ERR] = (s_r.engine_status[UKL_ENGINE_STATUS_CRC_ERR] &
        WDATA_IN[UKL_ENGINE_STATUS_CRC_ERR]) | SIE_EV_IN.crc_error;
      s_nxt.engine_status[UKL_ENGINE_STATUS_OUT] = (s_r.engine_status[UKL_ENGINE_STATUS_OUT] &
        WDATA_IN[UKL_ENGINE_STATUS_OUT] & ~SIE_EV_IN.setup_done) |
        SIE_EV_IN.out_received;
      s_nxt.engine_status[UKL_ENGINE_STATUS_FIFO0_ERROR_FLAG] = (s_r.engine_status[UKL_ENGINE_STATUS_FIFO0_ERROR_FLAG] &
        WDATA_IN[UKL_ENGINE_STATUS_FIFO0_ERROR_FLAG]) | SIE_EV_IN.fifo0_error;
    end else if (is_wr(UKL_OFF_EP_ENABLE)) begin
      s_nxt.ep_en = WDATA_IN[2:0]; // [RL18] [RL21]
    end
    if (!is_wr(UKL_OFF_ENGINE_STATUS)) begin
      s_nxt.engine_status[UKL_ENGINE_STATUS_CRC_ERR] =
        s_r.engine_status[UKL_ENGINE_STATUS_CRC_ERR] | SIE_EV_IN.crc_error;
      s_nxt.engine_status[UKL_ENGINE_STATUS_FIFO0_ERROR_FLAG] =
        s_r.engine_status[UKL_ENGINE_STATUS_FIFO0_ERROR_FLAG] | SIE_EV_IN.fifo0_error;
      s_nxt.engine_status[UKL_ENGINE_STATUS_OUT] = (s_r.engine_status[UKL_ENGINE_STATUS_OUT] &
        ~SIE_EV_IN.setup_done) | SIE_EV_IN.out_received;
    end

    s_nxt.dev_reset = s_r.system_control_reg[UKL_SCC_DEEP_SUSP] & LVR_OPTION_IN; // [RL3]

    // register reads
    if (RD_IN) begin
      if (ADDR_IN == UKL_OFF_USB_STATUS_CTRL) begin
        s_nxt.rdata = s_r.usb_status_control_reg; // [RL8]
      end else if (ADDR_IN == UKL_OFF_SYSTEM_CTRL) begin
        s_nxt.rdata = s_r.system_control_reg;
      end else if (ADDR_IN == UKL_OFF_IFACE_SELECT) begin
        s_nxt.rdata = s_r.sel;
      end else if (ADDR_IN == UKL_OFF_PIPE_DIRECTION) begin
        s_nxt.rdata = {5'h00, s_r.pipe_dir}; // [RL21]
      end else if (ADDR_IN == UKL_OFF_EP_STALL) begin
        s_nxt.rdata = {5'h00, s_r.stall}; // [RL21]
      end else if (ADDR_IN == UKL_OFF_EP_ACCESSED) begin
        s_nxt.rdata = {5'h00, s_r.accessed}; // [RL14] [RL21]
      end else if (ADDR_IN == UKL_OFF_ENGINE_STATUS) begin
        s_nxt.rdata = s_r.engine_status; // [RL19]
      end else if (ADDR_IN == UKL_OFF_EP_ENABLE) begin
        s_nxt.rdata = {5'h00, s_r.ep_en}; // [RL21]
      end else if (ADDR_IN == UKL_OFF_CUR_ADDR) begin
        s_nxt.rdata = {1'b0, s_r.cur_addr};
      end else begin
        s_nxt.rdata = UKL_BYTE_ZERO;
      end
    end
  end

  // =====================================================================
  // state register
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      s_r            <= '0;
      s_r.usb_status_control_reg        <= UKL_USC_RESET;
      s_r.system_control_reg        <= UKL_SCC_RESET;
      s_r.sel        <= UKL_BYTE_ZERO; // [RL11]
      s_r.pipe_dir   <= UKL_EP_RESET_ONES; // [RL16]
      s_r.addr_wake  <= UKL_BYTE_ZERO; // [RL12]
      s_r.stall      <= UKL_EP_RESET_ONES; // [RL15]
      s_r.accessed   <= UKL_EP_RESET_ZERO; // [RL14]
      s_r.ep_en      <= UKL_EP_RESET_ONES;
      s_r.engine_status       <= UKL_BYTE_ZERO;
    end else begin
      s_r <= s_nxt;
    end
  end

  // =====================================================================
  // outputs
  assign RDATA_OUT        = s_r.rdata;
  assign USB_CLK_EN_OUT   = s_r.system_control_reg[UKL_SCC_CLK_EN]; // [RL2]
  assign DEEP_SUSPEND_OUT = s_r.system_control_reg[UKL_SCC_DEEP_SUSP];
  assign DEVICE_RESET_OUT = s_r.dev_reset; // [RL3]
  assign USB_IRQ_OUT      = s_r.usb_irq;
  assign WAKE_PULSE_OUT   = (s_r.wake_cnt != '0); // [RL6]
  assign TOGGLE_CLEAR_OUT = s_r.toggle_clr; // [RL17]
  assign DEVICE_ADDR_OUT  = s_r.cur_addr;
  assign PIPE_DIR_OUT     = s_r.pipe_dir;
  assign EP_STALL_OUT     = s_r.stall;
  assign EP_ENABLE_OUT    = {s_r.ep_en[2:1], 1'b1}; // [RL18]
  assign USB_MODE_OUT     = usb_mode;
  assign PS2_MODE_OUT     = ps2_mode;

  // pins: ps2 is open drain, drive low only when the out bit is zero
  always_comb begin
    MINUS_OUT    = 1'b0;
    PLUS_OUT     = 1'b0;
    MINUS_OE_OUT = 1'b0;
    PLUS_OE_OUT  = 1'b0;
    if (ps2_mode) begin
      MINUS_OE_OUT = ~s_r.usb_status_control_reg[UKL_USC_KD_OUT]; // [RL7] [RL8]
      PLUS_OE_OUT  = ~s_r.usb_status_control_reg[UKL_USC_KC_OUT]; // [RL7] [RL8]
    end else if (usb_mode) begin
      MINUS_OUT    = SIE_MINUS_IN; // [RL10]
      PLUS_OUT     = SIE_PLUS_IN; // [RL10]
      MINUS_OE_OUT = SIE_OE_IN; // [RL10]
      PLUS_OE_OUT  = SIE_OE_IN; // [RL10]
    end
  end

endmodule : ukl_link_ctrl

// ---- ukl_link_ctrl_asserts.sv ----
// checker: port assertions of the link control block
module ukl_link_ctrl_asserts
  import ukl_pkg::*;
(
  input wire logic        CLK_SYS_IN,
  input wire logic        RST_IN,
  input wire logic [7:0]  ADDR_IN,
  input wire logic [7:0]  WDATA_IN,
  input wire logic        WR_IN,
  input wire logic        RD_IN,
  input wire logic [7:0]  RDATA_OUT,
  input wire logic        HOST_RESUME_IN,
  input wire logic        LVR_OPTION_IN,
  input wire ukl_sie_ev_t SIE_EV_IN,
  input wire logic        SIE_MINUS_IN,
  input wire logic        SIE_PLUS_IN,
  input wire logic        SIE_OE_IN,
  input wire logic        MINUS_OUT,
  input wire logic        MINUS_OE_OUT,
  input wire logic        PLUS_OUT,
  input wire logic        USB_CLK_EN_OUT,
  input wire logic        DEEP_SUSPEND_OUT,
  input wire logic        DEVICE_RESET_OUT,
  input wire logic        USB_IRQ_OUT,
  input wire logic        WAKE_PULSE_OUT,
  input wire logic [6:0]  DEVICE_ADDR_OUT,
  input wire logic [2:0]  EP_STALL_OUT,
  input wire logic        USB_MODE_OUT,
  input wire logic        PS2_MODE_OUT
);
  // =====================================================================
  // assertions
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);
  a_rdata_idle_zero: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
    else $error("read data not zero outside answer cycle");
  a_clock_enable_write: assert property (WR_IN && ADDR_IN == 8'h3D |=>
    USB_CLK_EN_OUT == $past(WDATA_IN[3])) else $error("usb clock enable");
  a_deep_lvr_reset: assert property (DEEP_SUSPEND_OUT && LVR_OPTION_IN
    |=> DEVICE_RESET_OUT) else $error("no device reset in deep suspend");
  a_resume_rise_irq: assert property ($rose(HOST_RESUME_IN) |=> USB_IRQ_OUT)
    else $error("no interrupt on resume start");
  a_resume_fall_irq: assert property ($fell(HOST_RESUME_IN) |=> USB_IRQ_OUT)
    else $error("no interrupt on resume end");
  a_wake_pulse_start: assert property (WR_IN && ADDR_IN == 8'h3C &&
    WDATA_IN[1] |=> WAKE_PULSE_OUT [*8]) else $error("wake pulse missing");
  a_usb_lines_engine: assert property (USB_MODE_OUT |->
    {MINUS_OE_OUT, MINUS_OUT, PLUS_OUT} ==
    {SIE_OE_IN, SIE_MINUS_IN, SIE_PLUS_IN}) else $error("lines not engine");
  a_ps2_mode_select: assert property (WR_IN && ADDR_IN == 8'h3E &&
    WDATA_IN[5:4] == 2'b01 |=> PS2_MODE_OUT && !USB_MODE_OUT)
    else $error("ps2 mode not selected");
  a_stall_reg_write: assert property (WR_IN && ADDR_IN == 8'h43 |=>
    EP_STALL_OUT == $past(WDATA_IN[2:0])) else $error("stall write lost");
  a_setup_addr_hold: assert property (SIE_EV_IN.setup_done && !WR_IN &&
    !SIE_EV_IN.in_read_done |=> $stable(DEVICE_ADDR_OUT))
    else $error("address loaded at setup");
  c_suspend_irq: cover property (USB_IRQ_OUT && !HOST_RESUME_IN);
  c_ps2_mode: cover property (PS2_MODE_OUT);
  c_wake: cover property ($rose(WAKE_PULSE_OUT));
endmodule : ukl_link_ctrl_asserts

bind ukl_link_ctrl ukl_link_ctrl_asserts i_ukl_link_ctrl_asserts (
  .CLK_SYS_IN, .RST_IN, .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT,
  .HOST_RESUME_IN, .LVR_OPTION_IN, .SIE_EV_IN, .SIE_MINUS_IN, .SIE_PLUS_IN,
  .SIE_OE_IN, .MINUS_OUT, .MINUS_OE_OUT, .PLUS_OUT, .USB_CLK_EN_OUT,
  .DEEP_SUSPEND_OUT, .DEVICE_RESET_OUT, .USB_IRQ_OUT, .WAKE_PULSE_OUT,
  .DEVICE_ADDR_OUT, .EP_STALL_OUT, .USB_MODE_OUT, .PS2_MODE_OUT);

// ---- ukl_host_model.sv ----
// model: usb host and keyboard host at the far side of the data lines
module ukl_host_model (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic idle_en_in,
  input  wire logic resume_en_in,
  input  wire logic kbd_dat_in,
  input  wire logic kbd_clk_in,
  input  wire logic wake_in,
  input  wire logic minus_in,
  input  wire logic minus_oe_in,
  input  wire logic plus_in,
  input  wire logic plus_oe_in,
  output logic      line_idle_out,
  output logic      host_resume_out,
  output logic      minus_lvl_out,
  output logic      plus_lvl_out
);
  // =====================================================================
  // host answers a finished wake pulse with resume signalling
  logic       wake_d_r;
  logic [3:0] ans_r;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wake_d_r <= 1'b0;
      ans_r    <= 4'h0;
    end else begin
      wake_d_r <= wake_in;
      if (wake_d_r && !wake_in) ans_r <= 4'hF;
      else if (ans_r != 4'h0) ans_r <= ans_r - 4'h1;
    end
  end
  assign host_resume_out = resume_en_in || ans_r != 4'h0;
  assign line_idle_out   = idle_en_in && !host_resume_out && !wake_in;
  // =====================================================================
  // line levels: device drive wins, else the keyboard host level
  assign minus_lvl_out = minus_oe_in ? minus_in : kbd_dat_in;
  assign plus_lvl_out  = plus_oe_in ? plus_in : kbd_clk_in;
endmodule : ukl_host_model

// ---- ukl_link_ctrl_tb_top.sv ----
// testbench: directed and random checks of the link control block
module ukl_link_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ukl_pkg::*;
  // =====================================================================
  // signals
  logic clk, rst, wr, rd, low_voltage_reset, sm, sp, soe, idl, res, kd, kc;
  logic mo, moe, po, poe, cken, deep, drst, irq, wake, tog, usbm, ps2m;
  logic ml, pl, lidle, hres;
  logic [7:0] addr, wd, rdata, r;
  logic [6:0] dad;
  logic [2:0] pdir, stl, een;
  logic [31:0] seed;
  ukl_sie_ev_t ev, lv;
  int err_total = 0, num_checks = 0, ntog = 0, nirq = 0, n, b;
  // =====================================================================
  // design and far side
  ukl_link_ctrl i_ukl_link_ctrl (.CLK_SYS_IN(clk), .RST_IN(rst),
    .ADDR_IN(addr), .WDATA_IN(wd), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
    .LINE_IDLE_IN(lidle), .HOST_RESUME_IN(hres), .LVR_OPTION_IN(low_voltage_reset),
    .SIE_EV_IN(ev), .MINUS_IN(ml), .PLUS_IN(pl), .SIE_MINUS_IN(sm),
    .SIE_PLUS_IN(sp), .SIE_OE_IN(soe), .MINUS_OUT(mo), .MINUS_OE_OUT(moe),
    .PLUS_OUT(po), .PLUS_OE_OUT(poe), .USB_CLK_EN_OUT(cken),
    .DEEP_SUSPEND_OUT(deep), .DEVICE_RESET_OUT(drst), .USB_IRQ_OUT(irq),
    .WAKE_PULSE_OUT(wake), .TOGGLE_CLEAR_OUT(tog), .DEVICE_ADDR_OUT(dad),
    .PIPE_DIR_OUT(pdir), .EP_STALL_OUT(stl), .EP_ENABLE_OUT(een),
    .USB_MODE_OUT(usbm), .PS2_MODE_OUT(ps2m));
  ukl_host_model i_ukl_host_model (.clk_in(clk), .rst_in(rst),
    .idle_en_in(idl), .resume_en_in(res), .kbd_dat_in(kd), .kbd_clk_in(kc),
    .wake_in(wake), .minus_in(mo), .minus_oe_in(moe), .plus_in(po),
    .plus_oe_in(poe), .line_idle_out(lidle), .host_resume_out(hres),
    .minus_lvl_out(ml), .plus_lvl_out(pl));
  // =====================================================================
  // helpers
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    ntog <= ntog + int'(tog);
    nirq <= nirq + int'(irq);
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask : tick
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wrr
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 r = rdata;
  endtask : rdr
  task automatic pulse(input ukl_sie_ev_t e);
    @(posedge clk);
    ev <= ukl_sie_ev_t'(e | lv);
    @(posedge clk);
    ev <= lv;
    #1;
  endtask : pulse
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  initial begin
    repeat (UKL_IDLE_CYCLES + 5000) @(posedge clk);
    err_total++;
    results();
  end
  // =====================================================================
  // tests
  initial begin
    {rst, wr, rd, low_voltage_reset, sm, sp, soe, idl, res, kd, kc} = 11'h400;
    {addr, wd} = 16'h0000;
    ev = '0;
    lv = '0;
    seed = 32'hBAC835EB;
    tick(10);
    rst <= 1'b0;
    rdr(8'h41);
    chk(r, 8'h07);
    rdr(8'h43);
    chk(r, 8'h07);
    rdr(8'h44);
    chk(r, 8'h00);
    chk({usbm, ps2m, dad}, 9'h000);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      wrr(8'h41, seed[7:0]);
      rdr(8'h41);
      chk(r, {5'h00, seed[2:0]});
      wrr(8'h47, seed[15:8]);
      chk(een[2:1], seed[10:9]);
      wrr(8'h44, seed[7:0]);
      rdr(8'h44);
      chk(r, 8'h00);
    end
    $display("register test done");
    pulse(ukl_sie_ev_t'(3'h5));
    rdr(8'h44);
    chk(r, 8'h05);
    wrr(8'h42, 8'hA7);
    chk(dad, 7'h53);
    wrr(8'h45, 8'h01);
    wrr(8'h42, 8'h64);
    chk(dad, 7'h53);
    pulse(ukl_sie_ev_t'({1'b0, 7'h00, 1'b1, 9'h000}));
    chk(dad, 7'h32);
    rdr(8'h45);
    chk(r[0], 1'b0);
    pulse(ukl_sie_ev_t'({1'b1, 7'h19, 10'h000}));
    chk(dad, 7'h32);
    pulse(ukl_sie_ev_t'({1'b0, 7'h00, 1'b1, 9'h000}));
    chk(dad, 7'h19);
    $display("address test done");
    lv = ukl_sie_ev_t'(18'h00188);
    pulse(ukl_sie_ev_t'(18'h00070));
    rdr(8'h45);
    chk(r, 8'h7E);
    wrr(8'h45, 8'h00);
    rdr(8'h45);
    chk(r, 8'h58);
    lv = '0;
    pulse('0);
    wrr(8'h3E, 8'h10);
    wrr(8'h3C, 8'hC0);
    for (int i = 0; i < 4; i++) begin
      {kc, kd} <= 2'(i);
      rdr(8'h3C);
      chk(r[7:4], {2'b11, 2'(i)});
    end
    wrr(8'h3C, 8'h00);
    rdr(8'h3C);
    chk(r[5:4], 2'b00);
    wrr(8'h3E, 8'h20);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      {soe, sm, sp} <= seed[2:0];
      tick(2);
      chk({moe, mo, po}, seed[2:0]);
    end
    $display("mode test done");
    low_voltage_reset <= 1'b1;
    wrr(8'h3D, 8'h10);
    tick(2);
    chk({cken, deep, drst}, 3'b011);
    wrr(8'h3D, 8'h08);
    low_voltage_reset <= 1'b0;
    b = ntog;
    wrr(8'h41, 8'h06);
    tick(10);
    wrr(8'h41, 8'h07);
    tick(4);
    chk(ntog - b, 1);
    wrr(8'h41, 8'h06);
    wrr(8'h41, 8'h07);
    tick(4);
    chk(ntog - b, 1);
    $display("toggle test done");
    b = nirq;
    n = 0;
    idl <= 1'b1;
    while (irq !== 1'b1 && n < UKL_IDLE_CYCLES + 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n > UKL_IDLE_CYCLES && n < UKL_IDLE_CYCLES + 10, 1);
    rdr(8'h3C);
    chk(r[0], 1'b1);
    res <= 1'b1;
    tick(3);
    rdr(8'h3C);
    chk(r[3], 1'b1);
    res <= 1'b0;
    idl <= 1'b0;
    tick(3);
    rdr(8'h3C);
    chk(r[0], 1'b0);
    chk(nirq - b, 3);
    wrr(8'h3C, 8'h02);
    tick(1);
    chk(wake, 1'b1);
    $display("suspend test done");
    results();
  end
endmodule : ukl_link_ctrl_tb_top
